// ==== rtl/bamr_defines.svh ====
`ifndef BAMR_DEFINES_SVH
`define BAMR_DEFINES_SVH

// ----------------------------------------------------------------------
// Slave address and command codes
// ----------------------------------------------------------------------
`define BAMR_SLAVE_ADDR      7'h0B
`define BAMR_CMD_CAP_THR     8'h01
`define BAMR_CMD_TIME_THR    8'h02
`define BAMR_CMD_MODE        8'h03
`define BAMR_CHARGER_ADDR    7'h09
`define BAMR_HOST_ADDR       7'h08

// ----------------------------------------------------------------------
// Mode word fields
// ----------------------------------------------------------------------
`define BAMR_MODE_RELEARN    7
`define BAMR_MODE_CC_EN      8
`define BAMR_MODE_PRIMARY    9
`define BAMR_MODE_ALARM_OFF  13
`define BAMR_MODE_CHG_OFF    14
`define BAMR_MODE_CAP_UNITS  15
`define BAMR_MODE_WR_MASK    16'hFC00

// ----------------------------------------------------------------------
// Alarm status bits and fixed values
// ----------------------------------------------------------------------
`define BAMR_STAT_CAP_ALARM  16'h0200
`define BAMR_STAT_TIME_ALARM 16'h0100
`define BAMR_ZERO16          16'h0000
`define BAMR_RELEARN_COUNT   5'h14

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define BAMR_CLK_HZ          10000000
`define BAMR_SUPPRESS_MS     59500
`define BAMR_BCAST_MS        10000
`define BAMR_REFRESH_MS      1000
`define BAMR_MS_CYCLES       (`BAMR_CLK_HZ / 1000)

`endif

// ==== rtl/bamr_pkg.sv ====
package bamr_pkg;

  // Word access from the bus engine.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] cmd;
    logic [15:0] data;
  } bamr_req_t;

  // Outgoing write-word broadcast.
  typedef struct packed {
    logic [6:0]  addr;
    logic [7:0]  cmd;
    logic [15:0] data;
  } bamr_bcast_t;

  typedef enum logic [1:0] {
    BAMR_IDLE,
    BAMR_TO_HOST,
    BAMR_TO_CHG
  } bamr_bst_t;

endpackage : bamr_pkg

// ==== rtl/bamr_ms_tick.sv ====
`timescale 1ns/1ns
`include "bamr_defines.svh"

// Millisecond enable pulse from the 10 MHz clock.
module bamr_ms_tick (
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic sys_rst_in,
  // Tick
  output logic      ms_tick_out
);

  logic [13:0] cnt_r;
  wire         wrap = (cnt_r == 14'(`BAMR_MS_CYCLES - 1));

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cnt_r       <= 14'h0000;
      ms_tick_out <= 1'b0;
    end else begin
      cnt_r       <= wrap ? 14'h0000 : cnt_r + 14'h0001;
      ms_tick_out <= wrap;
    end
  end

endmodule : bamr_ms_tick

// ==== rtl/bamr_ms_timer.sv ====
`timescale 1ns/1ns

// Millisecond down counter; restart loads the count, done pulses at zero.
module bamr_ms_timer (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  // Control
  input  wire logic        ms_tick_in,
  input  wire logic        restart_in,
  input  wire logic [16:0] load_in,
  // Status
  output logic             busy_out,
  output logic             done_out
);

  logic [16:0] cnt_r;
  wire         last = ms_tick_in && (cnt_r == 17'h00001);

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cnt_r    <= 17'h00000;
      done_out <= 1'b0;
    end else begin
      done_out <= last && !restart_in;
      if (restart_in)
        cnt_r <= load_in;
      else if (ms_tick_in && cnt_r != 17'h00000)
        cnt_r <= cnt_r - 17'h00001;
    end
  end

  assign busy_out = (cnt_r != 17'h00000);

endmodule : bamr_ms_timer

// ==== rtl/bamr_regs.sv ====
`timescale 1ns/1ns
`include "bamr_defines.svh"

module bamr_regs (
  // Clock and reset
  input  wire logic                 ref_clk_in,
  input  wire logic                 sys_rst_in,
  // Word access from the bus engine, with slave_addr_in matched here against our address
  input  wire logic [6:0]           slave_addr_in,
  input  wire bamr_pkg::bamr_req_t  req_in,
  output logic [15:0]               rd_data_out,
  output logic                      rd_valid_out,
  // Nonvolatile defaults
  input  wire logic [15:0]          nv_time_thr_in,
  input  wire logic [15:0]          nv_cap_thr_in,
  // Gauge inputs
  input  wire logic [15:0]          remaining_capacity_value_in,
  input  wire logic [15:0]          average_time_to_empty_a_in,
  input  wire logic                 calc_update_in,
  input  wire logic                 cycle_count_inc_in,
  input  wire logic                 full_capacity_update_in,
  input  wire logic                 learn_done_in,
  input  wire logic                 sleep_entry_in,
  input  wire logic [15:0]          charging_current_request_in,
  input  wire logic [15:0]          charging_voltage_request_in,
  input  wire logic                 charge_req_due_in,
  // Broadcast engine
  input  wire logic                 bcast_ready_in,
  output logic                      bcast_valid_out,
  output bamr_pkg::bamr_bcast_t     bcast_out,
  // Mode outputs
  output logic                      cap_units_out,
  output logic                      unit_refresh_out,
  output logic                      charge_bcast_en_out
);

  // --------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------
  wire addr_ok = (slave_addr_in == `BAMR_SLAVE_ADDR);
  wire wr_cap  = addr_ok && req_in.wr && req_in.cmd == `BAMR_CMD_CAP_THR;
  wire wr_time = addr_ok && req_in.wr && req_in.cmd == `BAMR_CMD_TIME_THR;
  wire wr_mode = addr_ok && req_in.wr && req_in.cmd == `BAMR_CMD_MODE;

  logic [15:0] cap_thr_r;
  logic [15:0] time_thr_r;
  logic        relearn_r;
  logic        alarm_off_r;
  logic        chg_off_r;
  logic        units_r;
  logic        init_r;
  logic [4:0]  cyc_cnt_r;
  logic        cap_alarm_r;
  logic        time_alarm_r;
  logic        ms_tick;
  logic        sup_busy;
  logic        sup_done;
  logic        gap_busy;
  logic        ref_done;
  logic        ref_busy;

  wire [15:0] mode_word = {units_r, chg_off_r, alarm_off_r, 3'b000,
                           2'b00, relearn_r, 7'h00};

  // --------------------------------------------------------------------
  // Threshold registers
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      init_r     <= 1'b1;
      cap_thr_r  <= `BAMR_ZERO16;
      time_thr_r <= `BAMR_ZERO16;
    end else begin
      init_r <= 1'b0;
      if (init_r) begin
        cap_thr_r  <= nv_cap_thr_in;
        time_thr_r <= nv_time_thr_in;
      end else begin
        if (wr_cap)
          cap_thr_r <= req_in.data;
        if (wr_time)
          time_thr_r <= req_in.data;
      end
    end
  end

  // --------------------------------------------------------------------
  // Mode word
  // --------------------------------------------------------------------
  wire relearn_due = cycle_count_inc_in &&
                     (cyc_cnt_r == `BAMR_RELEARN_COUNT - 5'h01);

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      relearn_r   <= 1'b1;
      alarm_off_r <= 1'b0;
      chg_off_r   <= 1'b0;
      units_r     <= 1'b0;
      cyc_cnt_r   <= 5'h00;
    end else begin
      if (full_capacity_update_in)
        cyc_cnt_r <= 5'h00;
      else if (cycle_count_inc_in && !relearn_due)
        cyc_cnt_r <= cyc_cnt_r + 5'h01;
      else if (relearn_due)
        cyc_cnt_r <= 5'h00;
      if (relearn_due)
        relearn_r <= 1'b1;
      else if (learn_done_in)
        relearn_r <= 1'b0;
      if (sleep_entry_in) begin
        alarm_off_r <= 1'b0;
        chg_off_r   <= 1'b0;
        units_r     <= 1'b0;
      end else if (wr_mode) begin
        alarm_off_r <= req_in.data[`BAMR_MODE_ALARM_OFF];
        chg_off_r   <= req_in.data[`BAMR_MODE_CHG_OFF];
        units_r     <= req_in.data[`BAMR_MODE_CAP_UNITS];
      end else if (sup_done) begin
        alarm_off_r <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Timers
  // --------------------------------------------------------------------
  bamr_ms_tick u_tick (
    .ref_clk_in  (ref_clk_in),
    .sys_rst_in  (sys_rst_in),
    .ms_tick_out (ms_tick)
  );

  // Midpoint of the 59 to 60 second window.
  bamr_ms_timer u_suppress (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .ms_tick_in (ms_tick),
    .restart_in (wr_mode),
    .load_in    (17'(`BAMR_SUPPRESS_MS)),
    .busy_out   (sup_busy),
    .done_out   (sup_done)
  );

  wire bcast_fire = bcast_valid_out && bcast_ready_in;
  wire alarm_sent = bcast_fire && bcast_out.cmd == 8'h16 &&
                    bcast_out.addr == `BAMR_CHARGER_ADDR;

  bamr_ms_timer u_gap (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .ms_tick_in (ms_tick),
    .restart_in (alarm_sent),
    .load_in    (17'(`BAMR_BCAST_MS)),
    .busy_out   (gap_busy),
    .done_out   ()
  );

  wire units_chg = wr_mode && (req_in.data[`BAMR_MODE_CAP_UNITS] != units_r);

  bamr_ms_timer u_refresh (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .ms_tick_in (ms_tick),
    .restart_in (units_chg),
    .load_in    (17'(`BAMR_REFRESH_MS)),
    .busy_out   (ref_busy),
    .done_out   (ref_done)
  );

  // --------------------------------------------------------------------
  // Alarm comparison
  // --------------------------------------------------------------------
  wire reeval  = calc_update_in || wr_cap || wr_time;
  wire cap_lo  = (cap_thr_r != `BAMR_ZERO16) &&
                 (remaining_capacity_value_in < cap_thr_r);
  wire time_lo = (time_thr_r != `BAMR_ZERO16) &&
                 (average_time_to_empty_a_in < time_thr_r);

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cap_alarm_r  <= 1'b0;
      time_alarm_r <= 1'b0;
    end else if (reeval) begin
      cap_alarm_r  <= cap_lo;
      time_alarm_r <= time_lo;
    end
  end

  // --------------------------------------------------------------------
  // Broadcast sequencer
  // --------------------------------------------------------------------
  wire [15:0] alarm_word = (cap_alarm_r ? `BAMR_STAT_CAP_ALARM : 16'h0000) |
                           (time_alarm_r ? `BAMR_STAT_TIME_ALARM : 16'h0000);
  wire alarm_go = (cap_alarm_r || time_alarm_r) && !alarm_off_r &&
                  !sup_busy && !gap_busy;
  wire chg_go   = charge_req_due_in && !chg_off_r;

  bamr_pkg::bamr_bst_t bst_r;
  logic                chg_phase_r;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      bst_r           <= bamr_pkg::BAMR_IDLE;
      bcast_valid_out <= 1'b0;
      bcast_out       <= '0;
      chg_phase_r     <= 1'b0;
    end else begin
      case (bst_r)
        bamr_pkg::BAMR_IDLE: begin
          if (alarm_go) begin
            bcast_out       <= '{`BAMR_HOST_ADDR, 8'h16, alarm_word};
            bcast_valid_out <= 1'b1;
            bst_r           <= bamr_pkg::BAMR_TO_HOST;
          end else if (chg_go) begin
            bcast_out       <= '{`BAMR_CHARGER_ADDR, 8'h14,
                                 charging_current_request_in};
            bcast_valid_out <= 1'b1;
            chg_phase_r     <= 1'b1;
            bst_r           <= bamr_pkg::BAMR_TO_CHG;
          end
        end
        bamr_pkg::BAMR_TO_HOST: begin
          if (bcast_fire) begin
            bcast_out.addr <= `BAMR_CHARGER_ADDR;
            bst_r          <= bamr_pkg::BAMR_TO_CHG;
          end
        end
        bamr_pkg::BAMR_TO_CHG: begin
          if (bcast_fire) begin
            if (chg_phase_r) begin
              bcast_out.cmd  <= 8'h15;
              bcast_out.data <= charging_voltage_request_in;
              chg_phase_r    <= 1'b0;
            end else begin
              bcast_valid_out <= 1'b0;
              bst_r           <= bamr_pkg::BAMR_IDLE;
            end
          end
        end
        default: begin
          bcast_valid_out <= 1'b0;
          bst_r           <= bamr_pkg::BAMR_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Read port and mode outputs
  // --------------------------------------------------------------------
  wire [15:0] rd_mux = (req_in.cmd == `BAMR_CMD_CAP_THR)  ? cap_thr_r  :
                       (req_in.cmd == `BAMR_CMD_TIME_THR) ? time_thr_r :
                       (req_in.cmd == `BAMR_CMD_MODE)     ? mode_word  :
                       `BAMR_ZERO16;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rd_data_out         <= `BAMR_ZERO16;
      rd_valid_out        <= 1'b0;
      cap_units_out       <= 1'b0;
      unit_refresh_out    <= 1'b0;
      charge_bcast_en_out <= 1'b1;
    end else begin
      rd_valid_out        <= addr_ok && req_in.rd;
      if (addr_ok && req_in.rd)
        rd_data_out <= rd_mux;
      cap_units_out       <= units_r;
      unit_refresh_out    <= ref_done && !ref_busy;
      charge_bcast_en_out <= !chg_off_r;
    end
  end

endmodule : bamr_regs

// ==== test/bamr_regs_properties.sv ====
`timescale 1ns/1ns

module bamr_regs_properties (
  // Clock and reset
  input  wire logic                  ref_clk_in,
  input  wire logic                  sys_rst_in,
  // Register access
  input  wire logic [6:0]            slave_addr_in,
  input  wire bamr_pkg::bamr_req_t   req_in,
  input  wire logic [15:0]           rd_data_out,
  input  wire logic                  rd_valid_out,
  input  wire logic                  sleep_entry_in,
  // Broadcast and mode outputs
  input  wire logic                  bcast_ready_in,
  input  wire logic                  bcast_valid_out,
  input  wire bamr_pkg::bamr_bcast_t bcast_out,
  input  wire logic                  cap_units_out,
  input  wire logic                  charge_bcast_en_out
);
  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  wire mode_rd = req_in.rd && slave_addr_in == 7'h0B && req_in.cmd == 8'h03;
  wire hs      = bcast_valid_out && bcast_ready_in;

  a_mode_low_zero: assert property (mode_rd |=> rd_valid_out &&
    rd_data_out[6:0] == 7'h00 && rd_data_out[9:8] == 2'h0)
    else $error("mode word low or unused bits not zero");
  a_foreign_addr: assert property (req_in.rd &&
    slave_addr_in != 7'h0B |=> !rd_valid_out)
    else $error("read answered at foreign address");
  a_chg_en_bit: assert property (mode_rd |=>
    rd_data_out[14] != charge_bcast_en_out)
    else $error("charge enable disagrees with mode bit");
  a_units_bit: assert property (mode_rd |=>
    rd_data_out[15] == cap_units_out)
    else $error("units output disagrees with mode bit");
  a_sleep_clears: assert property (sleep_entry_in |->
    ##[1:2] (!cap_units_out && charge_bcast_en_out))
    else $error("sleep entry did not clear mode bits");
  a_bcast_hold: assert property (bcast_valid_out &&
    !bcast_ready_in |=> bcast_valid_out && $stable(bcast_out))
    else $error("broadcast changed before handshake");
  a_bcast_target: assert property (bcast_valid_out |->
    bcast_out.addr inside {7'h08, 7'h09} &&
    bcast_out.cmd inside {8'h14, 8'h15, 8'h16})
    else $error("broadcast to wrong address or command");
  a_alarm_bits: assert property (bcast_valid_out &&
    bcast_out.cmd == 8'h16 |-> (bcast_out.data & 16'hFCFF) == 16'h0000
    && bcast_out.data[9:8] != 2'h0)
    else $error("alarm word carries wrong status bits");
  a_alarm_pair: assert property (hs && bcast_out.addr == 7'h08
    |-> ##[1:2] (bcast_valid_out && bcast_out.addr == 7'h09 &&
    bcast_out.cmd == 8'h16))
    else $error("host alarm not followed by charger alarm");

  c_mode_rd: cover property (mode_rd);
  c_alarm:   cover property (hs && bcast_out.cmd == 8'h16);
  c_charge:  cover property (hs && bcast_out.cmd == 8'h15);
  c_sleep:   cover property (sleep_entry_in);
endmodule : bamr_regs_properties

// ==== test/bamr_bcast_sink.sv ====
`timescale 1ns/1ns

module bamr_bcast_sink (
  // Clock
  input  wire logic                  ref_clk_in,
  // Broadcast handshake
  input  wire logic                  bcast_valid_in,
  input  wire bamr_pkg::bamr_bcast_t bcast_in,
  input  wire logic                  stall_in,
  output logic                       bcast_ready_out
);
  // --------------------------------------------------------------------
  // Receiver that logs each word taken; stalls answer one cycle in four.
  // --------------------------------------------------------------------
  bamr_pkg::bamr_bcast_t log_q[$];
  logic [1:0]            ph_r;

  initial begin
    ph_r = 2'h0;
    bcast_ready_out = 1'b0;
  end

  always @(posedge ref_clk_in) begin
    if (bcast_valid_in && bcast_ready_out) begin
      log_q.push_back(bcast_in);
    end
    ph_r <= ph_r + 2'h1;
    bcast_ready_out <= !stall_in || ph_r == 2'h3;
  end
endmodule : bamr_bcast_sink

// ==== test/tb_top.sv ====
`timescale 1ns/1ns

module tb_top;
  // --------------------------------------------------------------------
  // Stimulus and checking
  // --------------------------------------------------------------------
  logic clk, rst, calc, inc, fcu, learn, sleep, due, rv, bv, rdy, stall;
  logic units, refresh, chg_en;
  logic [6:0] addr;
  logic [15:0] rdat, cap, tte, rd_w;
  bamr_pkg::bamr_req_t req;
  bamr_pkg::bamr_bcast_t bc;
  int errors, comparisons;

  bamr_regs dut (.ref_clk_in(clk), .sys_rst_in(rst), .slave_addr_in(addr),
    .req_in(req), .rd_data_out(rdat), .rd_valid_out(rv),
    .nv_time_thr_in(16'h0045), .nv_cap_thr_in(16'h0123),
    .remaining_capacity_value_in(cap), .average_time_to_empty_a_in(tte),
    .calc_update_in(calc), .cycle_count_inc_in(inc),
    .full_capacity_update_in(fcu), .learn_done_in(learn),
    .sleep_entry_in(sleep), .charging_current_request_in(16'h1234),
    .charging_voltage_request_in(16'h5678), .charge_req_due_in(due),
    .bcast_ready_in(rdy), .bcast_valid_out(bv), .bcast_out(bc),
    .cap_units_out(units), .unit_refresh_out(refresh),
    .charge_bcast_en_out(chg_en));

  bamr_bcast_sink sink (.ref_clk_in(clk), .bcast_valid_in(bv),
    .bcast_in(bc), .stall_in(stall), .bcast_ready_out(rdy));

  always #50 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [7:0] c,
                    input logic [15:0] d);
    @(negedge clk); addr = a; req = '{1'b1, 1'b0, c, d};
    @(negedge clk); req = '0; addr = 7'h0B;
  endtask : wr

  task automatic rdc(input logic [7:0] c, input logic [15:0] exp);
    int n;
    n = 0;
    @(negedge clk); req = '{1'b0, 1'b1, c, 16'h0000};
    @(negedge clk); req = '0;
    while (rv !== 1'b1 && n < 4) begin
      @(negedge clk); n++;
    end
    chk("read_word", {16'h0000, rdat}, {16'h0000, exp});
  endtask : rdc

  task automatic pulse(ref logic s);
    @(negedge clk); s = 1'b1;
    @(negedge clk); s = 1'b0;
  endtask : pulse

  task automatic wait_cnt(input int n);
    int k;
    k = 0;
    while (sink.log_q.size() < n && k < 500) begin
      @(negedge clk); k++;
    end
  endtask : wait_cnt

  task automatic t_reset;
    rdc(8'h01, 16'h0123);
    rdc(8'h02, 16'h0045);
    rdc(8'h03, 16'h0080);
  endtask : t_reset

  task automatic t_alarm;
    wr(7'h0B, 8'h01, 16'h0100);
    wr(7'h0B, 8'h02, 16'h0005);
    rdc(8'h01, 16'h0100);
    cap = 16'h0100; tte = 16'h0005;
    pulse(calc);
    repeat (30) @(negedge clk);
    chk("no_alarm", 32'(sink.log_q.size()), 32'd0);
    cap = 16'h00FF; tte = 16'h0004; stall = 1'b1;
    pulse(calc);
    wait_cnt(2);
    chk("host", sink.log_q[0], {7'h08, 8'h16, 16'h0300});
    chk("chgr", sink.log_q[1], {7'h09, 8'h16, 16'h0300});
  endtask : t_alarm

  task automatic t_charge;
    pulse(due);
    wait_cnt(4);
    chk("cur", sink.log_q[2], {7'h09, 8'h14, 16'h1234});
    chk("volt", sink.log_q[3], {7'h09, 8'h15, 16'h5678});
    pulse(calc);
    repeat (50) @(negedge clk);
    chk("gap", 32'(sink.log_q.size()), 32'd4);
  endtask : t_charge

  task automatic t_mode;
    wr(7'h0B, 8'h03, 16'hFFFF);
    rdc(8'h03, 16'hE080);
    chk("units", {31'h0, units}, 32'h1);
    chk("chg_en", {31'h0, chg_en}, 32'h0);
    pulse(due);
    repeat (30) @(negedge clk);
    chk("chg_off", 32'(sink.log_q.size()), 32'd4);
    wr(7'h0C, 8'h03, 16'h0000);
    rdc(8'h03, 16'hE080);
    pulse(sleep);
    rdc(8'h03, 16'h0080);
    chk("chg_on", {31'h0, chg_en}, 32'h1);
  endtask : t_mode

  task automatic t_relearn;
    pulse(learn);
    rdc(8'h03, 16'h0000);
    repeat (19) pulse(inc);
    rdc(8'h03, 16'h0000);
    pulse(inc);
    rdc(8'h03, 16'h0080);
  endtask : t_relearn

  task automatic end_sim;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  initial begin
    #3000000;
    errors++;
    end_sim();
  end

  initial begin
    clk = 1'b0; rst = 1'b1; calc = 1'b0; inc = 1'b0; fcu = 1'b0;
    learn = 1'b0; sleep = 1'b0; due = 1'b0; stall = 1'b0;
    addr = 7'h0B; req = '0; cap = 16'hFFFF; tte = 16'hFFFF;
    errors = 0; comparisons = 0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reset();
    t_alarm();
    t_charge();
    t_mode();
    t_relearn();
    end_sim();
  end
endmodule : tb_top

bind bamr_regs bamr_regs_properties u_props (.ref_clk_in, .sys_rst_in,
  .slave_addr_in, .req_in, .rd_data_out, .rd_valid_out, .sleep_entry_in,
  .bcast_ready_in, .bcast_valid_out, .bcast_out, .cap_units_out,
  .charge_bcast_en_out);
